/* File: rtl/quasi_resonant_switch_timing.sv */
// turn-on timing, blanking, valley skipping, starter and supply sequencing
// assumes comparator inputs are clean synchronous levels from the analog front end
`timescale 1ns/1ps
module quasi_resonant_switch_timing (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // variant strap: high selects the fast oscillator
  input  wire logic highFreqVariant,
  // supply and input comparators
  input  wire logic belowSupplyOff,
  input  wire logic belowSupplyRestart,
  input  wire logic aboveSupplyOn,
  input  wire logic aboveStartInput,
  input  wire logic faultTrip,
  input  wire logic powerDown,
  // demag sense comparators
  input  wire logic aboveArmThreshold,
  input  wire logic aboveTriggerThreshold,
  input  wire logic aboveOneVolt,
  // feedback: burst request from light-load detect
  input  wire logic burstRequest,
  // switch control is the pwm turn-off request
  input  wire logic turnOffRequest,
  // outputs
  output logic      switchOn,
  output logic      chargeReducedEn,
  output logic      valleyMode,
  output logic      longBlankSel
);
  import qr_timing_pkg::*;

  typedef struct packed {
    supply_state_t    sup;
    logic             on;
    logic             armed;
    logic             valley;
    logic             longBlank;
    logic             armPrev;
    logic             trigPrev;
    logic             pending;
    logic [CNT_W-1:0] delayCnt;
    logic [CNT_W-1:0] blankCnt;
    logic [CNT_W-1:0] strobeCnt;
    logic             strobeDone;
    logic             started;
    logic             armSeen;
  } core_state_t;

  core_state_t st_ff;
  core_state_t nxt_st;

  logic oscDone;
  logic oscLoad;
  logic stDone;
  logic turnOn;
  logic turnOff;
  logic blanking;
  logic armRise;
  logic trigFall;
  logic running;
  logic stopping;
  logic [CNT_W-1:0] oscPeriod;

  ////////////////////////////////////////////////////////////////////////
  // oscillator and starter period counters, both restarted at turn-on
  assign oscPeriod = highFreqVariant ? OSC_HIGH_CYC : OSC_LOW_CYC;
  assign oscLoad   = turnOn;

  qr_down_counter u_osc (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .load      (oscLoad),
    .loadValue (oscPeriod),
    .done      (oscDone)
  );

  qr_down_counter u_starter (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .load      (oscLoad),
    .loadValue (STARTER_CYC),
    .done      (stDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge detection on the sense comparators
  assign running  = (st_ff.sup == ST_RUN);
  // a fault or low supply seen this edge stops the gate at once, not one cycle late
  assign stopping = running && (faultTrip || belowSupplyOff);
  assign blanking = (st_ff.blankCnt != CNT_ZERO);
  // no arming outside run or on a turn-on edge, so a starter pulse never looks locked
  assign armRise  = aboveArmThreshold && !st_ff.armPrev && !blanking && !st_ff.on
                    && running && !turnOn;
  assign trigFall = !aboveTriggerThreshold && st_ff.trigPrev && !blanking && !st_ff.on;
  assign turnOff  = st_ff.on && (turnOffRequest || !running || stopping);

  // turn-on: delayed valley edge, starter tick when not locked, or at once for the first pulse after entering run
  // blanking still active keeps turn-on back even after the period ends
  always_comb begin
    turnOn = 1'b0;
    if (running && !stopping && !st_ff.on && !blanking && !burstRequest) begin
      if (st_ff.pending && st_ff.delayCnt == CNT_ZERO) begin
        turnOn = 1'b1;
      end else if (!st_ff.valley && stDone) begin
        turnOn = 1'b1;
      end else if (!st_ff.started) begin
        turnOn = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.armPrev  = aboveArmThreshold;
    nxt_st.trigPrev = aboveTriggerThreshold;
    if (st_ff.delayCnt != CNT_ZERO) begin
      nxt_st.delayCnt = st_ff.delayCnt - CNT_ONE;
    end
    if (st_ff.blankCnt != CNT_ZERO) begin
      nxt_st.blankCnt = st_ff.blankCnt - CNT_ONE;
    end
    // supply sequencing
    unique case (st_ff.sup)
      ST_RUN: begin
        if (powerDown && belowSupplyOff) begin
          nxt_st.sup = ST_DOWN;
        end else if (faultTrip || belowSupplyOff) begin
          nxt_st.sup = ST_HALT;
        end
      end
      ST_HALT: begin
        if (belowSupplyRestart && aboveStartInput) begin
          nxt_st.sup = ST_RECHG;
        end
      end
      ST_RECHG: begin
        if (aboveSupplyOn) begin
          nxt_st.sup     = ST_RUN;
          nxt_st.started = 1'b0;
          nxt_st.valley  = 1'b0;
        end
      end
      ST_DOWN: begin
        nxt_st.sup = ST_DOWN;
      end
    endcase
    // arming and trigger acceptance
    if (armRise) begin
      nxt_st.armed  = 1'b1;
      nxt_st.valley = 1'b1;
    end
    if (trigFall && st_ff.armed) begin
      nxt_st.armed = 1'b0;
      if (oscDone && !st_ff.pending) begin
        nxt_st.pending  = 1'b1;
        nxt_st.delayCnt = DELAY_CYC;
      end
    end
    // arm-level sense anywhere in the off-time shows a live winding; a level, not an
    // edge, so a valley lost to blanking or an ignored edge does not drop the lock
    if (!st_ff.on && aboveArmThreshold) begin
      nxt_st.armSeen = 1'b1;
    end
    // period over without arming: back to starter
    if (oscDone && !st_ff.on && !st_ff.armSeen && !st_ff.pending && !blanking) begin
      nxt_st.valley = 1'b0;
    end
    // strobe sample picks next blanking length once per cycle
    if (!st_ff.on && !st_ff.strobeDone) begin
      if (st_ff.strobeCnt == CNT_ZERO) begin
        nxt_st.longBlank  = !aboveOneVolt;
        nxt_st.strobeDone = 1'b1;
      end else begin
        nxt_st.strobeCnt = st_ff.strobeCnt - CNT_ONE;
      end
    end
    if (turnOn) begin
      nxt_st.on      = 1'b1;
      nxt_st.pending = 1'b0;
      nxt_st.started = 1'b1;
      nxt_st.armSeen = 1'b0;
    end
    if (turnOff) begin
      nxt_st.on         = 1'b0;
      nxt_st.armed      = 1'b0;
      nxt_st.pending    = 1'b0;
      nxt_st.blankCnt   = st_ff.longBlank ? BLANK_LONG_CYC : BLANK_SHORT_CYC;
      nxt_st.strobeCnt  = STROBE_CYC;
      nxt_st.strobeDone = 1'b0;
    end
    // burst drops a waiting trigger: the next turn-on waits for a fresh valley
    if (!running || burstRequest) begin
      nxt_st.pending = 1'b0;
      nxt_st.armed   = 1'b0;
    end
  end

  // state register; start in recharge waiting for the on threshold
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff           <= '0;
      st_ff.sup       <= ST_RECHG;
      st_ff.longBlank <= 1'b1;
      st_ff.strobeDone <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign switchOn        = st_ff.on;
  assign chargeReducedEn = (st_ff.sup == ST_RECHG);
  assign valleyMode      = st_ff.valley;
  assign longBlankSel    = st_ff.longBlank;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_down_no_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_ff.sup == ST_DOWN |-> !switchOn ##1 (st_ff.sup == ST_DOWN))
    else $error("switch driven or left power-down");
  chk_restart_charge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_ff.sup == ST_HALT && belowSupplyRestart && aboveStartInput |=> chargeReducedEn)
    else $error("reduced charge not enabled");
  chk_resume_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_ff.sup == ST_RECHG && aboveSupplyOn |=> running)
    else $error("no resume at on threshold");
  chk_delay_turnon: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(st_ff.pending) |-> !switchOn [*8])
    else $error("turn-on before delay");
  chk_blank_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(switchOn) |=> !switchOn [*8])
    else $error("turn-on during blanking");
  chk_arm_cleared: assert property (@(posedge ref_clk) disable iff (sys_rst)
    turnOff |=> !st_ff.armed)
    else $error("armed survives turn-off");
  chk_early_ignore: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trigFall && !oscDone && !st_ff.pending |=> !st_ff.pending)
    else $error("early edge accepted");
  chk_blank_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st_ff.on && !st_ff.strobeDone && st_ff.strobeCnt == CNT_ZERO
    |=> longBlankSel == !$past(aboveOneVolt))
    else $error("wrong blanking length");
endmodule

/* File: rtl/qr_timing_pkg.sv */
// constants and types for the valley-switching turn-on timing block
// assumes a single 50 MHz clock; analog comparators arrive as synchronous levels
//
// Contract
// - below off threshold: stop switching, no restart (code: only with powerDown; without it, halt and auto-restart)
// - after fault halt; restart-level charge at reduced current
// - auto-restart resumes at supply on threshold
// - falling trigger edge turns switch on after delay
// - trigger accepted only after arming rising edge
// - blanking after turn-off ignores arm and trigger
// - oscillator caps frequency, resynced at turn-on
// - turn on at first valid edge after period
// - early edges ignored, later ringing edges re-evaluated
// - long blanking extends inhibit beyond period
// - two blanking lengths chosen by strobe sample
// - short blank above 1 V, long below
// - no arming by period end: fall to starter
// - starter frequency until arming, then valley locked
// - burst mode at very light load
// - trigger to turn-on delay 300 ns
package qr_timing_pkg;
  localparam int CLK_MHZ          = 50;
  localparam int DELAY_NS         = 300;
  localparam int BLANK_SHORT_NS   = 2500;
  localparam int BLANK_LONG_NS    = 6300;
  localparam int OSC_LOW_KHZ      = 136;
  localparam int OSC_HIGH_KHZ     = 225;
  localparam int STARTER_KHZ      = 22;
  localparam int STROBE_NS        = 1000;
  localparam int CNT_W            = 12;
  // least times round up, period rounds down
  localparam logic [CNT_W-1:0] DELAY_CYC =
    CNT_W'((DELAY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] BLANK_SHORT_CYC =
    CNT_W'((BLANK_SHORT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] BLANK_LONG_CYC =
    CNT_W'((BLANK_LONG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] OSC_LOW_CYC  = CNT_W'((CLK_MHZ * 1000) / OSC_LOW_KHZ);
  localparam logic [CNT_W-1:0] OSC_HIGH_CYC = CNT_W'((CLK_MHZ * 1000) / OSC_HIGH_KHZ);
  localparam logic [CNT_W-1:0] STARTER_CYC  = CNT_W'((CLK_MHZ * 1000) / STARTER_KHZ);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE      = 12'h001;

  typedef enum logic [3:0] {
    ST_HALT    = 4'h1,
    ST_RECHG   = 4'h2,
    ST_RUN     = 4'h4,
    ST_DOWN    = 4'h8
  } supply_state_t;
endpackage

/* File: rtl/qr_down_counter.sv */
// loadable down counter with a done flag
// assumes load and count never needed in the same cycle beyond load priority
`timescale 1ns/1ps
module qr_down_counter (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // control
  input  wire logic                           load,
  input  wire logic [qr_timing_pkg::CNT_W-1:0] loadValue,
  // status
  output logic                                done
);
  import qr_timing_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t st_ff;
  cnt_state_t nxt_st;

  // count to zero, reload wins
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.cnt = loadValue;
    end else if (st_ff.cnt != CNT_ZERO) begin
      nxt_st.cnt = st_ff.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = (st_ff.cnt == CNT_ZERO);
endmodule

/* File: verif/qr_far_side.sv */
// far-side model: switch on-time and auxiliary winding ringing
// assumes ring half period stays well above the turn-on delay
`timescale 1ns/1ps
module qr_far_side (
  // clock
  input  wire logic       ref_clk,
  // gate command from the block
  input  wire logic       switchOn,
  // scenario knobs from the bench
  input  wire logic       dead,
  input  wire logic       outHigh,
  input  wire logic [7:0] ringHalf,
  input  wire logic [8:0] onTime,
  // comparator levels and pwm end
  output logic            aboveArmThreshold,
  output logic            aboveTriggerThreshold,
  output logic            aboveOneVolt,
  output logic            turnOffRequest
);
  int   cnt    = 0;
  logic swPrev = 1'b0;
  logic senseHigh;
  ////////////////////////////////////////
  // cycles since the last gate change
  always_ff @(posedge ref_clk) begin
    swPrev <= switchOn;
    cnt    <= (switchOn != swPrev) ? 0 : cnt + 1;
  end
  // plateau of three half rings, then undamped ringing; low while on
  assign senseHigh = !dead && !switchOn &&
                     (cnt < 3 * ringHalf || (cnt / ringHalf) % 2 == 0);
  assign aboveArmThreshold     = senseHigh;
  assign aboveTriggerThreshold = senseHigh;
  assign aboveOneVolt          = senseHigh && outHigh;
  // swPrev guard: count still holds the off time in the first on cycle
  assign turnOffRequest        = switchOn && swPrev && cnt >= onTime;
endmodule

/* File: verif/quasi_resonant_switch_timing_test.sv */
// bench for the valley-switching timing block with a far-side model
// assumes the slow oscillator strap first, the fast one after a mid-run reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module quasi_resonant_switch_timing_test;
  import qr_timing_pkg::*;
  logic ref_clk, sys_rst, belowSupplyOff, belowSupplyRestart, aboveSupplyOn;
  logic aboveStartInput, faultTrip, powerDown, burstRequest, dead, outHigh, hiFreq;
  logic arm, trig, one, offReq, switchOn, chargeReducedEn, valleyMode, longBlankSel;
  logic [7:0] ringHalf;
  logic [8:0] onTime;
  logic       swPrev, trigPrev;
  int         n_fail, num_checks, cyc, lastTrigFall, lastRise, nRise;
  ////////////////////////////////////////
  quasi_resonant_switch_timing DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .highFreqVariant(hiFreq), .belowSupplyOff(belowSupplyOff),
    .belowSupplyRestart(belowSupplyRestart), .aboveSupplyOn(aboveSupplyOn),
    .aboveStartInput(aboveStartInput), .faultTrip(faultTrip), .powerDown(powerDown),
    .aboveArmThreshold(arm), .aboveTriggerThreshold(trig), .aboveOneVolt(one),
    .burstRequest(burstRequest), .turnOffRequest(offReq), .switchOn(switchOn),
    .chargeReducedEn(chargeReducedEn), .valleyMode(valleyMode),
    .longBlankSel(longBlankSel));
  qr_far_side far (.ref_clk(ref_clk), .switchOn(switchOn), .dead(dead),
    .outHigh(outHigh), .ringHalf(ringHalf), .onTime(onTime),
    .aboveArmThreshold(arm), .aboveTriggerThreshold(trig), .aboveOneVolt(one),
    .turnOffRequest(offReq));
  ////////////////////////////////////////
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // verdict and end of run
  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, about twice the planned run
  initial begin
    #(60000 * 20);
    n_fail++;
    report_and_stop();
  end
  // turn-on monitor; fresh random ringing per cycle keeps valley skipping varied
  always @(posedge ref_clk) begin
    cyc++;
    if (trigPrev === 1'b1 && trig === 1'b0) lastTrigFall = cyc;
    if (swPrev === 1'b0 && switchOn === 1'b1) begin
      nRise++;
      if (valleyMode === 1'b1 && !dead) begin
        // one edge to register the gate after the count hits zero, one more until it is seen here
        `CHK("trig delay", DELAY_CYC + 2, 12'(cyc - lastTrigFall))
        `CHK("period", 1'b1, cyc - lastRise >= (hiFreq ? OSC_HIGH_CYC : OSC_LOW_CYC))
      end
      if (valleyMode === 1'b0 && dead && lastRise > 0)
        `CHK("starter", 1'b1, cyc - lastRise inside {STARTER_CYC, STARTER_CYC + 1})
      lastRise = cyc;
      ringHalf <= 8'(20 + $urandom % 60);
      onTime   <= 9'(10 + $urandom % 30);
    end
    swPrev   = switchOn;
    trigPrev = trig;
  end
  // run the cycles
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////
  // supply sequencing and operating phases
  initial begin
    void'($urandom(32'h7c87bfae));
    {belowSupplyOff, belowSupplyRestart, aboveSupplyOn, aboveStartInput} = 4'h0;
    {faultTrip, powerDown, burstRequest, outHigh} = 4'h0;
    hiFreq = 1'b0;
    dead = 1'b1;
    ringHalf = 8'h20;
    onTime = 9'h014;
    sys_rst = 1'b1;
    run(4);
    @(posedge ref_clk) sys_rst <= 1'b0;
    run(1);
    `CHK("rst sw", 1'b0, switchOn)
    `CHK("rst chg", 1'b1, chargeReducedEn)
    `CHK("rst valley", 1'b0, valleyMode)
    `CHK("rst blank", 1'b1, longBlankSel)
    @(posedge ref_clk) aboveSupplyOn <= 1'b1;
    run(3 * STARTER_CYC + 50);
    `CHK("chg run", 1'b0, chargeReducedEn)
    `CHK("no arm", 1'b0, valleyMode)
    `CHK("starter n", 1'b1, nRise >= 3)
    @(posedge ref_clk) dead <= 1'b0;
    run(5000);
    `CHK("locked", 1'b1, valleyMode)
    `CHK("long blank", 1'b1, longBlankSel)
    @(posedge ref_clk) outHigh <= 1'b1;
    run(5000);
    `CHK("short blank", 1'b0, longBlankSel)
    @(posedge ref_clk) burstRequest <= 1'b1;
    run(50);
    nRise = 0;
    run(3000);
    `CHK("burst", 0, nRise)
    @(posedge ref_clk) {burstRequest, aboveSupplyOn, faultTrip} <= 3'b001;
    run(2);
    @(posedge ref_clk) faultTrip <= 1'b0;
    run(20);
    `CHK("halt sw", 1'b0, switchOn)
    `CHK("halt chg", 1'b0, chargeReducedEn)
    @(posedge ref_clk) {belowSupplyRestart, aboveStartInput} <= 2'b11;
    run(3);
    `CHK("rechg", 1'b1, chargeReducedEn)
    @(posedge ref_clk) {belowSupplyRestart, aboveSupplyOn} <= 2'b01;
    run(3);
    `CHK("resume", 1'b0, chargeReducedEn)
    nRise = 0;
    run(3000);
    `CHK("resume sw", 1'b1, nRise > 0)
    @(posedge ref_clk) {powerDown, belowSupplyOff} <= 2'b11;
    run(3);
    `CHK("down sw", 1'b0, switchOn)
    @(posedge ref_clk) {powerDown, belowSupplyOff} <= 2'b00;
    nRise = 0;
    run(3000);
    `CHK("no restart", 0, nRise)
    // mid-run reset with the fast strap; only reset leaves power-down
    @(posedge ref_clk) {sys_rst, hiFreq, aboveSupplyOn} <= 3'b110;
    run(4);
    `CHK("rst2 sw", 1'b0, switchOn)
    `CHK("rst2 chg", 1'b1, chargeReducedEn)
    @(posedge ref_clk) sys_rst <= 1'b0;
    run(2);
    `CHK("rst2 wait", 1'b1, chargeReducedEn)
    @(posedge ref_clk) aboveSupplyOn <= 1'b1;
    nRise = 0;
    run(5000);
    `CHK("fast locked", 1'b1, valleyMode)
    `CHK("fast sw", 1'b1, nRise > 4)
    report_and_stop();
  end
endmodule
